/* File: core/ssq_pace_if.sv */
// Interface: pacing control and ticks between sequencer and pacer
`timescale 1ns/1ps
interface ssq_pace_if;
  logic rateFast;
  logic run;
  logic [15:0] scanPeriod;
  logic paceTick;
  logic scanTick;
  modport pacer (input rateFast, input run, input scanPeriod, output paceTick, output scanTick);
  modport seq (output rateFast, output run, output scanPeriod, input paceTick, input scanTick);
endinterface : ssq_pace_if

/* File: core/ssq_pacer.sv */
// Pacing clock divider and scan-period timebase
`timescale 1ns/1ps
module ssq_pacer (
  input wire logic ref_clk,
  input wire logic resetn,
  ssq_pace_if.pacer pif
);
  logic [10:0] divCnt;
  logic [15:0] scanCnt;
  logic paceHit;

  assign paceHit = pif.run &&
    (divCnt == (pif.rateFast ? ssq_pkg::PACE_FAST_CYC : ssq_pkg::PACE_SLOW_CYC) - 11'h001);

  ////////////////////////////////////////////////////////////////////////////
  // selectable pacing rate
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt <= 11'h000;
      pif.paceTick <= 1'b0;
    end
    else
    begin
      pif.paceTick <= paceHit;
      if (!pif.run || paceHit)
        divCnt <= 11'h000;
      else
        divCnt <= divCnt + 11'h001;
    end
  end

  // scan timebase tick
  // A period of zero behaves as one, so the timebase never stalls
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scanCnt <= 16'h0000;
      pif.scanTick <= 1'b0;
    end
    else
    begin
      pif.scanTick <= 1'b0;
      if (!pif.run)
        scanCnt <= 16'h0000;
      else if (paceHit)
      begin
        if (scanCnt + 16'h0001 >= pif.scanPeriod)
        begin
          scanCnt <= 16'h0000;
          pif.scanTick <= 1'b1;
        end
        else
          scanCnt <= scanCnt + 16'h0001;
      end
    end
  end
endmodule : ssq_pacer

/* File: core/ssq_pkg.sv */
// Package: register map, field layout, timing and states of the scan sequencer
package ssq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PACE_SLOW_NS = 10000;
  localparam int PACE_FAST_NS = 5000;
  localparam logic [10:0] PACE_SLOW_CYC = 11'(PACE_SLOW_NS / CLK_PERIOD_NS);
  localparam logic [10:0] PACE_FAST_CYC = 11'(PACE_FAST_NS / CLK_PERIOD_NS);

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LAST = 8'h04;
  localparam logic [7:0] REG_PERIOD = 8'h08;
  localparam logic [7:0] REG_PRE = 8'h0C;
  localparam logic [7:0] REG_POST = 8'h10;
  localparam logic [7:0] REG_THRESH = 8'h14;
  localparam logic [7:0] REG_LPTR = 8'h18;
  localparam logic [7:0] REG_LDATA = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;

  localparam int CTRL_RATE = 0;
  localparam int CTRL_ARM = 1;
  localparam int CTRL_SWTRIG = 2;
  localparam int CTRL_SRC_LO = 4;
  localparam int CTRL_HOLD = 8;

  localparam int ENT_BASE_LO = 0;
  localparam int ENT_EXP_LO = 4;
  localparam int ENT_GAIN_LO = 8;
  localparam int ENT_BIP = 11;
  localparam int ENT_XGAIN_LO = 12;
  localparam int ENT_W = 14;
  localparam int LIST_DEPTH = 256;

  localparam logic [15:0] PERIOD_RST = 16'h0001;
  localparam logic [1:0] SRC_SOFT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_ANALOG = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_POST = 2'b11,
    ST_WAIT = 2'b10
  } ssq_state_t;
endpackage : ssq_pkg

/* File: core/ssq_sequencer.sv */
// Scan sequencer top: scan list, trigger control, expansion select and hold
`timescale 1ns/1ps
module ssq_sequencer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic extTrig,
  input wire logic trigCompare,
  output logic [15:0] thresholdOut,
  output logic dacReserved,
  output logic convStart,
  input wire logic adcValid,
  input wire logic [15:0] adcData,
  output logic sampleValid,
  output logic [15:0] sampleData,
  output logic [7:0] sampleEntry,
  output logic samplePre,
  output logic [3:0] baseSel,
  output logic [3:0] expAddr,
  output logic [2:0] localGain,
  output logic [1:0] expGain,
  output logic bipolar,
  output logic holdStrobe
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ssq_pace_if pif ();
  ssq_pacer u_pacer (.ref_clk(ref_clk), .resetn(resetn), .pif(pif));

  // 256 entries, held channels share one strobe
  logic [ssq_pkg::ENT_W-1:0] listMem [ssq_pkg::LIST_DEPTH];
  logic rateFast, rateLive, holdEn, scanHold;
  logic [1:0] trigSrc;
  logic [7:0] lastEntry, listPtr, entryIdx;
  logic [15:0] scanPeriod, preCount, postCount, postLeft;
  ssq_pkg::ssq_state_t state;
  logic armReq, swTrig, extPrev, cmpPrev, trigFire;
  logic scanPending, busy, lastIssued, scanIsPre, startScan, scanDone;
  logic [ssq_pkg::ENT_W-1:0] curEnt;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign armReq = regWr && hit(regAddr, ssq_pkg::REG_CTRL) && regWdata[ssq_pkg::CTRL_ARM];
  assign swTrig = regWr && hit(regAddr, ssq_pkg::REG_CTRL) && regWdata[ssq_pkg::CTRL_SWTRIG];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rateFast <= 1'b0;
      trigSrc <= ssq_pkg::SRC_SOFT;
      holdEn <= 1'b0;
      lastEntry <= 8'h00;
      scanPeriod <= ssq_pkg::PERIOD_RST;
      preCount <= 16'h0000;
      postCount <= 16'h0000;
      thresholdOut <= 16'h0000;
      listPtr <= 8'h00;
    end
    else if (regWr)
    begin
      if (hit(regAddr, ssq_pkg::REG_CTRL))
      begin
        rateFast <= regWdata[ssq_pkg::CTRL_RATE];
        trigSrc <= regWdata[ssq_pkg::CTRL_SRC_LO +: 2];
        holdEn <= regWdata[ssq_pkg::CTRL_HOLD];
      end
      if (hit(regAddr, ssq_pkg::REG_LAST))
        lastEntry <= regWdata[7:0];
      if (hit(regAddr, ssq_pkg::REG_PERIOD))
        scanPeriod <= regWdata[15:0];
      if (hit(regAddr, ssq_pkg::REG_PRE))
        preCount <= regWdata[15:0];
      if (hit(regAddr, ssq_pkg::REG_POST))
        postCount <= regWdata[15:0];
      if (hit(regAddr, ssq_pkg::REG_THRESH))
        thresholdOut <= regWdata[15:0];
      if (hit(regAddr, ssq_pkg::REG_LPTR))
        listPtr <= regWdata[7:0];
      else if (hit(regAddr, ssq_pkg::REG_LDATA))
        listPtr <= listPtr + 8'h01;
    end
  end

  // any channel at any list position
  always_ff @(posedge ref_clk)
  begin
    if (regWr && hit(regAddr, ssq_pkg::REG_LDATA))
      listMem[listPtr] <= regWdata[ssq_pkg::ENT_W-1:0];
  end

  // Read data stands one cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      regRdata <= 32'h00000000;
    else if (!regRd)
      regRdata <= 32'h00000000;
    else
      unique case (regAddr)
        ssq_pkg::REG_CTRL: regRdata <= {23'h0, holdEn, 2'h0, trigSrc, 3'h0, rateFast};
        ssq_pkg::REG_LAST: regRdata <= {24'h000000, lastEntry};
        ssq_pkg::REG_PERIOD: regRdata <= {16'h0000, scanPeriod};
        ssq_pkg::REG_PRE: regRdata <= {16'h0000, preCount};
        ssq_pkg::REG_POST: regRdata <= {16'h0000, postCount};
        ssq_pkg::REG_THRESH: regRdata <= {16'h0000, thresholdOut};
        ssq_pkg::REG_LPTR: regRdata <= {24'h000000, listPtr};
        ssq_pkg::REG_LDATA: regRdata <= {18'h0, listMem[listPtr]};
        ssq_pkg::REG_STATUS: regRdata <= {postLeft, entryIdx, 4'h0, holdStrobe, busy, state};
        default: regRdata <= 32'h00000000;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pacing: rate only follows the register while disarmed, so gaps stay exact
  // rate latched for the acquisition
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rateLive <= 1'b0;
    else if (state == ssq_pkg::ST_IDLE && !busy)
      rateLive <= rateFast;
  end

  assign pif.rateFast = rateLive;
  assign pif.run = (state != ssq_pkg::ST_IDLE) || busy;
  assign pif.scanPeriod = scanPeriod;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources
  // source select; analog mode claims the threshold output
  assign dacReserved = (trigSrc == ssq_pkg::SRC_ANALOG);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      extPrev <= 1'b0;
      cmpPrev <= 1'b0;
    end
    else
    begin
      extPrev <= extTrig;
      cmpPrev <= trigCompare;
    end
  end

  always_comb
  begin
    unique case (trigSrc)
      ssq_pkg::SRC_EXT: trigFire = extTrig && !extPrev;
      ssq_pkg::SRC_ANALOG: trigFire = trigCompare && !cmpPrev;
      default: trigFire = swTrig;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ssq_pkg::ST_IDLE;
      postLeft <= 16'h0000;
    end
    else
      unique case (state)
        ssq_pkg::ST_IDLE:
          if (armReq)
          begin
            postLeft <= postCount;
            state <= (preCount != 16'h0000) ? ssq_pkg::ST_PRE : ssq_pkg::ST_WAIT;
          end
        ssq_pkg::ST_PRE, ssq_pkg::ST_WAIT:
          if (trigFire)
            state <= (postLeft == 16'h0000) ? ssq_pkg::ST_IDLE : ssq_pkg::ST_POST;
        ssq_pkg::ST_POST:
          if (scanDone && !scanIsPre)
          begin
            postLeft <= postLeft - 16'h0001;
            if (postLeft == 16'h0001)
              state <= ssq_pkg::ST_IDLE;
          end
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan engine
  // a tick during a busy scan waits, and a new tick wins over the clear
  assign startScan = scanPending && !busy &&
    (state == ssq_pkg::ST_PRE || state == ssq_pkg::ST_POST);
  assign scanDone = adcValid && busy && lastIssued;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      scanPending <= 1'b0;
    else if (pif.scanTick)
      scanPending <= 1'b1;
    else if (startScan || state == ssq_pkg::ST_IDLE || state == ssq_pkg::ST_WAIT)
      scanPending <= 1'b0;
  end

  // walk entries 0 to lastEntry; one conversion per pacing tick
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      entryIdx <= 8'h00;
      lastIssued <= 1'b0;
      scanIsPre <= 1'b0;
      scanHold <= 1'b0;
      convStart <= 1'b0;
      sampleEntry <= 8'h00;
    end
    else
    begin
      convStart <= 1'b0;
      if (startScan)
      begin
        busy <= 1'b1;
        entryIdx <= 8'h00;
        lastIssued <= 1'b0;
        scanIsPre <= (state == ssq_pkg::ST_PRE);
        scanHold <= holdEn;
      end
      else if (scanDone)
        busy <= 1'b0;
      else if (busy && pif.paceTick && !lastIssued)
      begin
        convStart <= 1'b1;
        sampleEntry <= entryIdx;
        if (entryIdx == lastEntry)
          lastIssued <= 1'b1;
        else
          entryIdx <= entryIdx + 8'h01;
      end
    end
  end

  // hold strobe spans the whole scan
  // held channels are stepped while the strobe stays high
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      holdStrobe <= 1'b0;
    else if (startScan)
      holdStrobe <= holdEn;
    else if (scanDone)
      holdStrobe <= 1'b0;
  end

  // per-entry gain; base and expansion select
  // expansion lines follow the same pace as local selects
  // Selects load the cycle after each convStart and settle one cycle short of a pacing period before the next conversion
  assign curEnt = listMem[entryIdx];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      baseSel <= 4'h0;
      expAddr <= 4'h0;
      localGain <= 3'h0;
      expGain <= 2'h0;
      bipolar <= 1'b0;
    end
    else if (busy && !convStart && !lastIssued)
    begin
      baseSel <= curEnt[ssq_pkg::ENT_BASE_LO +: 4];
      expAddr <= curEnt[ssq_pkg::ENT_EXP_LO +: 4];
      localGain <= curEnt[ssq_pkg::ENT_GAIN_LO +: 3];
      expGain <= curEnt[ssq_pkg::ENT_XGAIN_LO +: 2];
      bipolar <= curEnt[ssq_pkg::ENT_BIP];
    end
  end

  // samples tagged pre or post trigger for downstream retention
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sampleValid <= 1'b0;
      sampleData <= 16'h0000;
      samplePre <= 1'b0;
    end
    else
    begin
      sampleValid <= adcValid && busy;
      if (adcValid && busy)
      begin
        sampleData <= adcData;
        samplePre <= scanIsPre;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic [10:0] gapCnt;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      gapCnt <= 11'h000;
    else if (convStart || startScan)
      gapCnt <= 11'h000;
    else if (gapCnt != 11'h7FF)
      gapCnt <= gapCnt + 11'h001;
  end

  pace_spacing_a: assert property (
    convStart && sampleEntry != 8'h00 |->
      gapCnt == (rateLive ? ssq_pkg::PACE_FAST_CYC : ssq_pkg::PACE_SLOW_CYC) - 11'h001)
    else $error("conversion spacing wrong");
  entry_gain_a: assert property (
    convStart |-> {expGain, localGain, bipolar} ==
      {listMem[sampleEntry][ssq_pkg::ENT_XGAIN_LO +: 2],
      listMem[sampleEntry][ssq_pkg::ENT_GAIN_LO +: 3], listMem[sampleEntry][ssq_pkg::ENT_BIP]})
    else $error("gain not from entry");
  sel_route_a: assert property (
    convStart |-> {expAddr, baseSel} == listMem[sampleEntry][7:0])
    else $error("select not from entry");
  hold_span_a: assert property (
    convStart && scanHold |-> holdStrobe throughout (busy [*2]))
    else $error("hold dropped during scan");
  scan_start_a: assert property (
    startScan |=> busy && entryIdx == 8'h00 && !lastIssued)
    else $error("scan start wrong");
  wait_quiet_a: assert property (
    state == ssq_pkg::ST_WAIT |=> !$rose(busy))
    else $error("scan during idle wait");
  arm_first_a: assert property (
    state == ssq_pkg::ST_IDLE && !armReq |=> state == ssq_pkg::ST_IDLE)
    else $error("left idle without arming");
  post_disarm_a: assert property (
    state == ssq_pkg::ST_POST && scanDone && !scanIsPre && postLeft == 16'h0001
      |=> state == ssq_pkg::ST_IDLE)
    else $error("no disarm after post count");
  pre_run_a: assert property (
    state == ssq_pkg::ST_PRE && scanPending && !busy |=> busy)
    else $error("pre-trigger scan not started");
endmodule : ssq_sequencer

/* File: testbench/scan_sequencer_trigger_tb.sv */
// Self-checking testbench of the scan sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    check_count++; \
    if ((gt) !== (ex)) \
    begin \
      num_errors++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module scan_sequencer_trigger_tb;
  logic ref_clk, resetn, regWr, regRd, extTrig, trigCompare, adcValid, slow;
  logic [7:0] regAddr, sampleEntry;
  logic [31:0] regWdata, regRdata, d;
  logic [15:0] adcData, thresholdOut, sampleData;
  logic dacReserved, convStart, sampleValid, samplePre, bipolar, holdStrobe;
  logic [3:0] baseSel, expAddr;
  logic [2:0] localGain;
  logic [1:0] expGain;
  int num_errors, check_count, cyc;
  int ct[$];
  logic [24:0] smp[$];
  // Channels deliberately out of order, with extreme select values
  logic [13:0] ent [3] = '{{2'h2, 1'h1, 3'h5, 4'hF, 4'h9}, {2'h0, 1'h0, 3'h0, 4'h0, 4'h2},
                          {2'h3, 1'h1, 3'h7, 4'h3, 4'hE}};
  ////////////////////////////////////////////////////////////////////////////////
  ssq_sequencer u_dut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .extTrig(extTrig), .trigCompare(trigCompare), .thresholdOut(thresholdOut),
    .dacReserved(dacReserved), .convStart(convStart), .adcValid(adcValid),
    .adcData(adcData), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleEntry(sampleEntry), .samplePre(samplePre), .baseSel(baseSel),
    .expAddr(expAddr), .localGain(localGain), .expGain(expGain), .bipolar(bipolar),
    .holdStrobe(holdStrobe));
  ssq_conv_model u_conv (.ref_clk(ref_clk), .resetn(resetn), .slow(slow),
    .convStart(convStart), .holdStrobe(holdStrobe), .baseSel(baseSel),
    .expAddr(expAddr), .localGain(localGain), .expGain(expGain), .bipolar(bipolar),
    .adcValid(adcValid), .adcData(adcData));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (convStart === 1'h1)
      ct.push_back(cyc);
    if (sampleValid === 1'h1)
      smp.push_back({samplePre, sampleEntry, sampleData});
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'h0;
    // Read data stand for this one cycle; take them at its closing edge
    @(posedge ref_clk);
    v = regRdata;
  endtask : rd
  task automatic wait_smp(input int n);
    int k;
    k = 0;
    while (smp.size() < n && k < 20000)
    begin
      @(posedge ref_clk);
      k++;
    end
    `CHK("samples arrived", 1'h1, smp.size() >= n)
  endtask : wait_smp
  function automatic logic [15:0] exp_d(input logic [13:0] e, input logic h);
    return {h, e[11], e[10:8], 1'h0, e[13:12], e[7:4], e[3:0]};
  endfunction : exp_d
  task automatic check_scan(input int f, input logic h, input logic p);
    for (int i = 0; i < 3; i++)
    begin
      `CHK("entry order", 8'(i), smp[f+i][23:16])
      `CHK("entry selects", exp_d(ent[i], h), smp[f+i][15:0])
      `CHK("pre flag", p, smp[f+i][24])
    end
  endtask : check_scan
  // Rate is written before arming: the pacer only takes it while idle
  task automatic arm(input logic [31:0] c, input int pre, input int post);
    wr(ssq_pkg::REG_PRE, 32'(pre));
    wr(ssq_pkg::REG_POST, 32'(post));
    wr(ssq_pkg::REG_CTRL, c);
    smp.delete();
    ct.delete();
    wr(ssq_pkg::REG_CTRL, c | 32'h0000_0002);
  endtask : arm
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    rd(ssq_pkg::REG_PERIOD, d);
    `CHK("period reset", 32'(ssq_pkg::PERIOD_RST), d)
    rd(8'h3C, d);
    `CHK("unmapped read", 32'h0000_0000, d)
    wr(ssq_pkg::REG_THRESH, 32'h0000_ABCD);
    wr(ssq_pkg::REG_CTRL, 32'h0000_0020);
    @(negedge ref_clk);
    `CHK("threshold out", 16'hABCD, thresholdOut)
    `CHK("output taken", 1'h1, dacReserved)
    wr(ssq_pkg::REG_CTRL, 32'h0000_0000);
    @(negedge ref_clk);
    `CHK("output free", 1'h0, dacReserved)
    wr(ssq_pkg::REG_LPTR, 32'h0000_00FF);
    wr(ssq_pkg::REG_LDATA, 32'h0000_2A5C);
    wr(ssq_pkg::REG_LPTR, 32'h0000_00FF);
    rd(ssq_pkg::REG_LDATA, d);
    `CHK("last list slot", 32'h0000_2A5C, d)
    wr(ssq_pkg::REG_LPTR, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      wr(ssq_pkg::REG_LDATA, 32'(ent[i]));
    wr(ssq_pkg::REG_LAST, 32'h0000_0002);
    // Period longer than a slow scan, so idle gaps exist between scans
    wr(ssq_pkg::REG_PERIOD, 32'h0000_0004);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_soft;
    arm(32'h0000_0101, 0, 2);
    extTrig <= 1'h1;
    repeat (3000) @(posedge ref_clk);
    extTrig <= 1'h0;
    `CHK("no scans before trigger", 0, ct.size())
    rd(ssq_pkg::REG_STATUS, d);
    `CHK("waiting state", ssq_pkg::ST_WAIT, d[1:0])
    wr(ssq_pkg::REG_CTRL, 32'h0000_0105);
    wait_smp(6);
    check_scan(0, 1'h1, 1'h0);
    check_scan(3, 1'h1, 1'h0);
    `CHK("pace spacing", int'(ssq_pkg::PACE_FAST_CYC), ct[1] - ct[0])
    `CHK("pace spacing", int'(ssq_pkg::PACE_FAST_CYC), ct[2] - ct[1])
    `CHK("scan overlap", 1'h1, ct[3] - ct[2] >= int'(ssq_pkg::PACE_FAST_CYC))
    `CHK("scan period", 4 * int'(ssq_pkg::PACE_FAST_CYC), ct[3] - ct[0])
    repeat (3000) @(posedge ref_clk);
    `CHK("post scan total", 6, smp.size())
    rd(ssq_pkg::REG_STATUS, d);
    `CHK("disarmed", ssq_pkg::ST_IDLE, d[1:0])
    $display("test_soft done");
  endtask : test_soft
  task automatic test_ext;
    slow <= 1'h1;
    arm(32'h0000_0110, 1, 1);
    wait_smp(3);
    check_scan(0, 1'h1, 1'h1);
    // Trigger between scans so no scan is split across the trigger point
    extTrig <= 1'h1;
    repeat (3) @(posedge ref_clk);
    extTrig <= 1'h0;
    wait_smp(6);
    check_scan(3, 1'h1, 1'h0);
    `CHK("slow spacing", int'(ssq_pkg::PACE_SLOW_CYC), ct[1] - ct[0])
    repeat (4000) @(posedge ref_clk);
    `CHK("post scan total", 6, smp.size())
    slow <= 1'h0;
    $display("test_ext done");
  endtask : test_ext
  task automatic test_analog;
    arm(32'h0000_0021, 0, 1);
    `CHK("output taken", 1'h1, dacReserved)
    trigCompare <= 1'h1;
    wait_smp(3);
    trigCompare <= 1'h0;
    check_scan(0, 1'h0, 1'h0);
    repeat (3000) @(posedge ref_clk);
    `CHK("post scan total", 3, smp.size())
    $display("test_analog done");
  endtask : test_analog
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial
  begin
    {resetn, regWr, regRd, extTrig, trigCompare, slow} = 6'h00;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'h1;
    test_regs();
    test_soft();
    test_ext();
    test_analog();
    results();
  end
  // Whole run needs about 32000 cycles
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    results();
  end
endmodule : scan_sequencer_trigger_tb

/* File: testbench/ssq_conv_model.sv */
// Model of the converter and expansion cards behind the select lines
`timescale 1ns/1ps
module ssq_conv_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic convStart,
  input wire logic holdStrobe,
  input wire logic [3:0] baseSel,
  input wire logic [3:0] expAddr,
  input wire logic [2:0] localGain,
  input wire logic [1:0] expGain,
  input wire logic bipolar,
  output logic adcValid,
  output logic [15:0] adcData
);
  logic [15:0] snap;
  int waitN;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      adcValid <= 1'h0;
      adcData <= 16'h0000;
      snap <= 16'h0000;
      waitN <= 0;
    end
    else
    begin
      adcValid <= 1'h0;
      // Released bus inverts each cycle, so a stale result shows every other cycle
      adcData <= ~adcData;
      if (convStart)
      begin
        // held value routed by the selects at the sampling edge
        snap <= {holdStrobe, bipolar, localGain, 1'h0, expGain, expAddr, baseSel};
        waitN <= slow ? 20 : 1;
      end
      else if (waitN == 1)
      begin
        adcValid <= 1'h1;
        adcData <= snap;
        waitN <= 0;
      end
      else if (waitN > 1)
      begin
        waitN <= waitN - 1;
      end
    end
  end
endmodule : ssq_conv_model
